// ===== rtl/hbd_pkg.sv
// Shared constants for the host buffer descriptor block
package hbd_pkg;
    // Register byte offsets on the APB bus
    localparam logic [11:0] HBD_CTRL_OFS = 12'h000;
    localparam logic [11:0] HBD_SIZE_OFS = 12'h004;
    localparam logic [11:0] HBD_LIST_LO_OFS = 12'h008;
    localparam logic [11:0] HBD_LIST_HI_OFS = 12'h00c;
    localparam logic [11:0] HBD_COUNT_OFS = 12'h010;
    localparam logic [11:0] HBD_STATUS_OFS = 12'h014;
    localparam logic [11:0] HBD_ATTR_IDX_OFS = 12'h018;
    localparam logic [11:0] HBD_ATTR_DATA_OFS = 12'h01c;
    localparam logic [11:0] HBD_PAGE_SHIFT_OFS = 12'h020;
    localparam logic [11:0] HBD_TOTAL_OFS = 12'h024;
    // Status bit positions
    localparam int HBD_ST_BUSY = 0;
    localparam int HBD_ST_SEQ_ERR = 1;
    localparam int HBD_ST_SEG_ERR = 2;
    localparam int HBD_ST_DONE = 3;
    // Descriptor entry layout
    localparam int HBD_ENTRY_BYTES = 16;
    localparam int HBD_ADDR_MSB = 63;
    localparam int HBD_PAGES_LSB = 64;
    localparam int HBD_PAGES_MSB = 95;
    // List base low bits treated as zero
    localparam int HBD_LIST_ALIGN_BITS = 4;
    // Attribute structure dword indices; all others read zero
    localparam logic [9:0] HBD_ATTR_SIZE_DW = 10'h000;
    localparam logic [9:0] HBD_ATTR_LO_DW = 10'h001;
    localparam logic [9:0] HBD_ATTR_HI_DW = 10'h002;
    localparam logic [9:0] HBD_ATTR_CNT_DW = 10'h003;
    // Reset values
    localparam logic [4:0] HBD_PAGE_SHIFT_RST = 5'h0c;
    // Walker states
    typedef enum logic [1:0] {
        HBD_IDLE = 2'b00,
        HBD_REQ = 2'b01,
        HBD_WAIT = 2'b10,
        HBD_DRAIN = 2'b11
    } hbd_walk_e;
    // Mask of in-page offset bits for a page of 2**shift bytes
    function automatic logic [63:0] hbd_page_mask(input logic [4:0] shift);
        hbd_page_mask = (64'h0000_0000_0000_0001 << shift) - 64'h0000_0000_0000_0001;
    endfunction
endpackage

// ===== rtl/hbd_walk_if.sv
// Link between the register front end and the descriptor walker
`timescale 1ns/1ps
`default_nettype none
interface hbd_walk_if;
    logic start;            // Pulse: begin walking the active list
    logic abort;            // Level: buffer being disabled
    logic [63:0] base_addr; // List base, low bits already zero
    logic [31:0] entry_count;
    logic [4:0] page_shift;
    logic busy;
    logic done;             // Pulse: last entry consumed, or empty list started
    logic seg_err;          // Pulse: segment start not page aligned
    logic seg_valid;
    logic [63:0] seg_addr;
    logic [31:0] seg_pages;
    logic mem_req_valid;
    logic mem_req_ready;
    logic [63:0] mem_req_addr;
    logic mem_rsp_valid;
    logic [127:0] mem_rsp_data;
    modport front (output start, abort, base_addr, entry_count, page_shift, mem_req_ready,
        mem_rsp_valid, mem_rsp_data, input busy, done, seg_err, seg_valid, seg_addr,
        seg_pages, mem_req_valid, mem_req_addr);
    modport walker (input start, abort, base_addr, entry_count, page_shift, mem_req_ready,
        mem_rsp_valid, mem_rsp_data, output busy, done, seg_err, seg_valid, seg_addr,
        seg_pages, mem_req_valid, mem_req_addr);
endinterface
`default_nettype wire

// ===== rtl/hbd_walker.sv
// Descriptor list walker: fetches entries and splits them into segments
`timescale 1ns/1ps
`default_nettype none
module hbd_walker
    import hbd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    hbd_walk_if.walker w
);
    hbd_walk_e state_reg, state_next;  // Walk progress
    logic [31:0] idx_reg, idx_next;    // Entry being fetched
    logic seg_valid_reg, seg_valid_next;
    logic [63:0] seg_addr_reg, seg_addr_next;
    logic [31:0] seg_pages_reg, seg_pages_next;
    logic done_reg, done_next;
    logic err_reg, err_next;
    logic last;

    assign last = (idx_reg + 32'h0000_0001) >= w.entry_count;  // Final index is count-1
    assign w.busy = (state_reg != HBD_IDLE);
    assign w.mem_req_valid = (state_reg == HBD_REQ) && !w.abort;  // No fetch while disabling
    assign w.mem_req_addr = w.base_addr + {idx_reg[27:0], 4'h0};  // Entry k at 16*k
    assign w.seg_valid = seg_valid_reg;
    assign w.seg_addr = seg_addr_reg;
    assign w.seg_pages = seg_pages_reg;
    assign w.done = done_reg;
    assign w.seg_err = err_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state: fetch, then decode each returned entry
    always_comb
    begin
        state_next = state_reg;
        idx_next = idx_reg;
        seg_valid_next = 1'b0;
        seg_addr_next = seg_addr_reg;
        seg_pages_next = seg_pages_reg;
        done_next = 1'b0;
        err_next = 1'b0;
        case (state_reg)
            HBD_IDLE:
            begin
                // An empty list finishes at once
                if (w.start && !w.abort)
                begin
                    idx_next = 32'h0000_0000;
                    state_next = (w.entry_count == 32'h0000_0000) ? HBD_IDLE : HBD_REQ;
                    done_next = (w.entry_count == 32'h0000_0000);
                end
            end
            HBD_REQ:
            begin
                // Request not yet taken can simply be withdrawn
                if (w.abort)
                    state_next = HBD_IDLE;
                else if (w.mem_req_ready)
                    state_next = HBD_WAIT;
            end
            HBD_WAIT:
            begin
                // A read in flight must still land; one landing now needs no drain
                if (w.abort)
                    state_next = w.mem_rsp_valid ? HBD_IDLE : HBD_DRAIN;
                else if (w.mem_rsp_valid)
                begin
                    // Address and page count fields; reserved top dword ignored
                    seg_valid_next = 1'b1;
                    seg_addr_next = w.mem_rsp_data[HBD_ADDR_MSB:0];
                    seg_pages_next = w.mem_rsp_data[HBD_PAGES_MSB:HBD_PAGES_LSB];
                    // Flag a start the host failed to page align
                    err_next = |(w.mem_rsp_data[HBD_ADDR_MSB:0] & hbd_page_mask(w.page_shift));
                    idx_next = idx_reg + 32'h0000_0001;
                    state_next = last ? HBD_IDLE : HBD_REQ;
                    done_next = last;
                end
            end
            HBD_DRAIN:
            begin
                // Response discarded: disabled buffer data is never used
                if (w.mem_rsp_valid)
                    state_next = HBD_IDLE;
            end
            default:
                state_next = HBD_IDLE;
        endcase
    end

    // Registers only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= HBD_IDLE;
            idx_reg <= 32'h0000_0000;
            seg_valid_reg <= 1'b0;
            seg_addr_reg <= 64'h0000_0000_0000_0000;
            seg_pages_reg <= 32'h0000_0000;
            done_reg <= 1'b0;
            err_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            idx_reg <= idx_next;
            seg_valid_reg <= seg_valid_next;
            seg_addr_reg <= seg_addr_next;
            seg_pages_reg <= seg_pages_next;
            done_reg <= done_next;
            err_reg <= err_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_walk_addr;
        @(posedge pclk) disable iff (!presetn)
        w.mem_req_valid |-> w.mem_req_addr == w.base_addr + {idx_reg[27:0], 4'h0};
    endproperty
    a_walk_addr: assert property (p_walk_addr) else $error("entry address not 16*k");

    property p_walk_pages;
        @(posedge pclk) disable iff (!presetn)
        (state_reg == HBD_WAIT && !w.abort && w.mem_rsp_valid) |=>
            seg_valid_reg && seg_pages_reg == $past(w.mem_rsp_data[95:64]);
    endproperty
    a_walk_pages: assert property (p_walk_pages) else $error("page count misdecoded");

    property p_walk_addr_field;
        @(posedge pclk) disable iff (!presetn)
        seg_valid_reg |-> seg_addr_reg == $past(w.mem_rsp_data[63:0]);
    endproperty
    a_walk_addr_field: assert property (p_walk_addr_field) else $error("segment address bad");

    property p_walk_abort;
        @(posedge pclk) disable iff (!presetn)
        w.abort |-> !w.mem_req_valid ##1 !seg_valid_reg;
    endproperty
    a_walk_abort: assert property (p_walk_abort) else $error("access while disabling");

    property p_walk_count;
        @(posedge pclk) disable iff (!presetn)
        done_reg && $past(state_reg) == HBD_WAIT |-> idx_reg == w.entry_count;
    endproperty
    a_walk_count: assert property (p_walk_count) else $error("walk stopped at wrong entry");
endmodule
`default_nettype wire

// ===== rtl/hbd_top.sv
// Host buffer descriptor front end: APB registers, attribute report, walker
// Notes on behaviour
// - List is 16-byte entries, last at count-1
// - Entry gives page-aligned byte start and page count
// - Bits 95:64 page count, 127:96 reserved
// - Dword 0 bit 0 reports buffer enabled
// - Attribute structure bytes 4095:16 reserved
// - Bytes 3:0 report buffer size in pages
// - Bytes 7:4, 11:8 report list address
// - Bytes 15:12 report valid entry count
// - List address low four bits taken zero
// - No buffer access after disabling completes
`timescale 1ns/1ps
`default_nettype none
module hbd_top
    import hbd_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic mem_req_valid,
    input wire logic mem_req_ready,
    output logic [63:0] mem_req_addr,
    input wire logic mem_rsp_valid,
    input wire logic [127:0] mem_rsp_data,
    output logic seg_valid,
    output logic [63:0] seg_addr,
    output logic [31:0] seg_pages
);
    hbd_walk_if w();

    logic buffer_enabled_flag_reg, buffer_enabled_flag_next;  // Buffer in use
    logic [31:0] size_reg, size_next;                // Staged size
    logic [31:0] lo_reg, lo_next;                    // Staged list address low
    logic [31:0] hi_reg, hi_next;                    // Staged list address high
    logic [31:0] cnt_reg, cnt_next;                  // Staged entry count
    logic [31:0] act_size_reg, act_size_next;        // Active buffer size
    logic [31:0] list_address_low_reg, list_address_low_next;
    logic [31:0] list_address_high_reg, list_address_high_next;
    logic [31:0] list_entry_count_reg, list_entry_count_next;
    logic [4:0] configured_page_size_reg, configured_page_size_next;  // log2 bytes
    logic [9:0] attr_idx_reg, attr_idx_next;         // Dword index into attributes
    logic seq_err_reg, seq_err_next;                 // Sticky: enable while enabled
    logic seg_err_reg, seg_err_next;                 // Sticky: misaligned segment
    logic done_reg, done_next;                       // Sticky: walk finished
    logic [31:0] total_reg, total_next;              // Pages described so far
    logic start_reg, start_next;                     // Walker kick
    logic [31:0] prdata_reg, prdata_next;
    logic setup, access, wr, mapped, ctrl_wr, disable_wr;
    logic [31:0] rd_word, attr_word;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign ctrl_wr = access && pwrite && (paddr == HBD_CTRL_OFS);
    assign disable_wr = ctrl_wr && !pwdata[0];
    // A disable write waits until any fetch in flight has landed
    assign pready = !(disable_wr && w.busy);
    assign wr = access && pwrite && pready;
    assign mapped = (paddr[1:0] == 2'b00) && (paddr <= HBD_TOTAL_OFS);
    assign pslverr = access && !mapped;
    assign prdata = prdata_reg;

    // Walker wiring
    assign w.start = start_reg;
    assign w.abort = disable_wr && buffer_enabled_flag_reg;
    // List base low bits forced to zero, never checked
    assign w.base_addr = {list_address_high_reg,
        list_address_low_reg[31:HBD_LIST_ALIGN_BITS], {HBD_LIST_ALIGN_BITS{1'b0}}};
    assign w.entry_count = list_entry_count_reg;
    assign w.page_shift = configured_page_size_reg;
    assign w.mem_req_ready = mem_req_ready;
    assign w.mem_rsp_valid = mem_rsp_valid;
    assign w.mem_rsp_data = mem_rsp_data;
    assign mem_req_valid = w.mem_req_valid;
    assign mem_req_addr = w.mem_req_addr;
    assign seg_valid = w.seg_valid;
    assign seg_addr = w.seg_addr;
    assign seg_pages = w.seg_pages;

    hbd_walker u_walker (
        .pclk(pclk),
        .presetn(presetn),
        .w(w)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Attribute structure, one dword at a time; unlisted dwords are zero
    always_comb
    begin
        case (attr_idx_reg)
            HBD_ATTR_SIZE_DW: attr_word = act_size_reg;
            HBD_ATTR_LO_DW: attr_word = list_address_low_reg;
            HBD_ATTR_HI_DW: attr_word = list_address_high_reg;
            HBD_ATTR_CNT_DW: attr_word = list_entry_count_reg;
            default: attr_word = 32'h0000_0000;
        endcase
    end

    // Read mux
    always_comb
    begin
        case (paddr)
            // Completion dword 0: enable flag, upper bits zero
            HBD_CTRL_OFS: rd_word = {31'h0000_0000, buffer_enabled_flag_reg};
            HBD_SIZE_OFS: rd_word = size_reg;
            HBD_LIST_LO_OFS: rd_word = lo_reg;
            HBD_LIST_HI_OFS: rd_word = hi_reg;
            HBD_COUNT_OFS: rd_word = cnt_reg;
            HBD_STATUS_OFS: rd_word = {28'h000_0000, done_reg, seg_err_reg, seq_err_reg, w.busy};
            HBD_ATTR_IDX_OFS: rd_word = {22'h00_0000, attr_idx_reg};
            HBD_ATTR_DATA_OFS: rd_word = attr_word;
            HBD_PAGE_SHIFT_OFS: rd_word = {27'h000_0000, configured_page_size_reg};
            HBD_TOTAL_OFS: rd_word = total_reg;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register next values
    always_comb
    begin
        buffer_enabled_flag_next = buffer_enabled_flag_reg;
        size_next = size_reg;
        lo_next = lo_reg;
        hi_next = hi_reg;
        cnt_next = cnt_reg;
        act_size_next = act_size_reg;
        list_address_low_next = list_address_low_reg;
        list_address_high_next = list_address_high_reg;
        list_entry_count_next = list_entry_count_reg;
        configured_page_size_next = configured_page_size_reg;
        attr_idx_next = attr_idx_reg;
        start_next = 1'b0;
        total_next = w.seg_valid ? total_reg + w.seg_pages : total_reg;
        // Read data is captured in the setup cycle so it stands from a flop
        prdata_next = (setup && !pwrite) ? rd_word : prdata_reg;
        // Sticky flags: hardware set wins over a one-to-clear in the same cycle
        seq_err_next = seq_err_reg;
        seg_err_next = seg_err_reg | w.seg_err;
        done_next = done_reg | w.done;
        if (wr)
        begin
            case (paddr)
                HBD_CTRL_OFS:
                begin
                    if (pwdata[0] && buffer_enabled_flag_reg)
                        seq_err_next = 1'b1;  // Enable while enabled is refused
                    else if (pwdata[0])
                    begin
                        // Commit staged attributes and start the walk
                        buffer_enabled_flag_next = 1'b1;
                        act_size_next = size_reg;
                        list_address_low_next = {lo_reg[31:HBD_LIST_ALIGN_BITS],
                            {HBD_LIST_ALIGN_BITS{1'b0}}};
                        list_address_high_next = hi_reg;
                        list_entry_count_next = cnt_reg;
                        total_next = 32'h0000_0000;
                        start_next = 1'b1;
                    end
                    else
                        buffer_enabled_flag_next = 1'b0;
                end
                HBD_SIZE_OFS: size_next = pwdata;
                HBD_LIST_LO_OFS: lo_next = pwdata;
                HBD_LIST_HI_OFS: hi_next = pwdata;
                HBD_COUNT_OFS: cnt_next = pwdata;
                HBD_STATUS_OFS:
                begin
                    seq_err_next = seq_err_reg & ~pwdata[HBD_ST_SEQ_ERR];
                    seg_err_next = (seg_err_reg & ~pwdata[HBD_ST_SEG_ERR]) | w.seg_err;
                    done_next = (done_reg & ~pwdata[HBD_ST_DONE]) | w.done;
                end
                HBD_ATTR_IDX_OFS: attr_idx_next = pwdata[9:0];
                HBD_PAGE_SHIFT_OFS: configured_page_size_next = pwdata[4:0];
                default: ;
            endcase
        end
    end

    // Registers only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            buffer_enabled_flag_reg <= 1'b0;
            size_reg <= 32'h0000_0000;
            lo_reg <= 32'h0000_0000;
            hi_reg <= 32'h0000_0000;
            cnt_reg <= 32'h0000_0000;
            act_size_reg <= 32'h0000_0000;
            list_address_low_reg <= 32'h0000_0000;
            list_address_high_reg <= 32'h0000_0000;
            list_entry_count_reg <= 32'h0000_0000;
            configured_page_size_reg <= HBD_PAGE_SHIFT_RST;
            attr_idx_reg <= 10'h000;
            seq_err_reg <= 1'b0;
            seg_err_reg <= 1'b0;
            done_reg <= 1'b0;
            total_reg <= 32'h0000_0000;
            start_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            buffer_enabled_flag_reg <= buffer_enabled_flag_next;
            size_reg <= size_next;
            lo_reg <= lo_next;
            hi_reg <= hi_next;
            cnt_reg <= cnt_next;
            act_size_reg <= act_size_next;
            list_address_low_reg <= list_address_low_next;
            list_address_high_reg <= list_address_high_next;
            list_entry_count_reg <= list_entry_count_next;
            configured_page_size_reg <= configured_page_size_next;
            attr_idx_reg <= attr_idx_next;
            seq_err_reg <= seq_err_next;
            seg_err_reg <= seg_err_next;
            done_reg <= done_next;
            total_reg <= total_next;
            start_reg <= start_next;
            prdata_reg <= prdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_dw0;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == HBD_CTRL_OFS) |=>
            prdata[31:1] == 31'h0000_0000 && prdata[0] == $past(buffer_enabled_flag_reg);
    endproperty
    a_dw0: assert property (p_dw0) else $error("dword 0 readback wrong");

    property p_reserved;
        @(posedge pclk) disable iff (!presetn)
        (attr_idx_reg > HBD_ATTR_CNT_DW) |-> attr_word == 32'h0000_0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved attribute nonzero");

    property p_attr_fields;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == HBD_CTRL_OFS && pwdata[0] && !buffer_enabled_flag_reg) |=>
            act_size_reg == $past(size_reg) && list_entry_count_reg == $past(cnt_reg)
            && list_address_high_reg == $past(hi_reg);
    endproperty
    a_attr_fields: assert property (p_attr_fields) else $error("attributes not committed");

    property p_list_align;
        @(posedge pclk) disable iff (!presetn)
        w.base_addr[3:0] == 4'h0 && list_address_low_reg[3:0] == 4'h0;
    endproperty
    a_list_align: assert property (p_list_align) else $error("list base low bits set");

    property p_disable_quiet;
        @(posedge pclk) disable iff (!presetn)
        (wr && disable_wr) |=> !buffer_enabled_flag_reg && !mem_req_valid [*2];
    endproperty
    a_disable_quiet: assert property (p_disable_quiet) else $error("fetch after disable");
endmodule
`default_nettype wire

// ===== verif/hbd_mem_model.sv
// Host memory model that serves descriptor list entries
`timescale 1ns/1ps
`default_nettype none
module hbd_mem_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic mem_req_valid,
    output logic mem_req_ready,
    input wire logic [63:0] mem_req_addr,
    output logic mem_rsp_valid,
    output logic [127:0] mem_rsp_data
);
logic pend_reg; // Fetch in flight
logic [1:0] cnt_reg; // Extra latency left
logic [63:0] addr_reg; // Entry address taken
logic [127:0] entry; // Entry made from its own address
////////////////////////////////////////////////////////////////
// Entry k: 4 KiB-aligned start, pages = address bits 35:4 plus 1, reserved filled
assign entry = {32'hdead_beef, addr_reg[35:4] + 32'h1, addr_reg << 12};
// Data lines never hold a stale entry between responses
assign mem_rsp_data = mem_rsp_valid ? entry : ~entry;
// One fetch outstanding; slow mode adds three cycles
assign mem_req_ready = !pend_reg && !mem_rsp_valid;
always_ff @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        pend_reg <= 1'b0;
        cnt_reg <= 2'h0;
        addr_reg <= 64'h0;
        mem_rsp_valid <= 1'b0;
    end
    else
    begin
        mem_rsp_valid <= 1'b0;
        if (mem_req_valid && mem_req_ready)
        begin
            pend_reg <= 1'b1;
            cnt_reg <= slow ? 2'h3 : 2'h0;
            addr_reg <= mem_req_addr;
        end
        else if (pend_reg && cnt_reg == 2'h0)
        begin
            pend_reg <= 1'b0;
            mem_rsp_valid <= 1'b1;
        end
        else if (pend_reg)
            cnt_reg <= cnt_reg - 2'h1;
    end
end
endmodule
`default_nettype wire

// ===== verif/hbd_top_tb_top.sv
// Register-level testbench for the host buffer descriptor block
`timescale 1ns/1ps
`default_nettype none
module hbd_top_tb_top;
import hbd_pkg::*;
logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
logic [11:0] paddr = 0;
logic [31:0] pwdata = 0, prdata, seg_pages, rd;
logic pready, pslverr, mem_req_valid, mem_req_ready, mem_rsp_valid, seg_valid, err;
logic [63:0] mem_req_addr, seg_addr;
logic [127:0] mem_rsp_data;
logic [63:0] sa[$]; // Segments seen, in order
logic [31:0] sp[$];
logic [31:0] ex[6] = '{32'h40, 32'h1000_0000, 32'h2, 32'h3, 32'h0, 32'h0};
logic [9:0] ix[6] = '{10'h0, 10'h1, 10'h2, 10'h3, 10'h4, 10'h3ff};
int num_errors = 0, checks_done = 0, cyc = 0, nreq = 0, n, m;
always #5 pclk = ~pclk;
hbd_top i_hbd_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mem_req_valid, .mem_req_ready, .mem_req_addr, .mem_rsp_valid,
    .mem_rsp_data, .seg_valid, .seg_addr, .seg_pages);
hbd_mem_model i_hbd_mem_model (.pclk, .presetn, .slow, .mem_req_valid, .mem_req_ready,
    .mem_req_addr, .mem_rsp_valid, .mem_rsp_data);
////////////////////////////////////////////////////////////////
// Collect segments and fetches; cut a hang short
always @(posedge pclk)
begin
    cyc++;
    if (seg_valid === 1'b1)
    begin
        sa.push_back(seg_addr);
        sp.push_back(seg_pages);
    end
    if (mem_req_valid === 1'b1 && mem_req_ready === 1'b1)
        nreq++;
    if (cyc == 20000)
    begin
        num_errors++;
        final_report();
    end
end
task automatic final_report;
    if (num_errors == 0 && checks_done > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
endtask
task automatic chk(input string s, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e)
    begin
        num_errors++;
        $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
endtask
// One APB transfer; holds the request until pready, then one idle cycle
task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++t < 200);
    if (t >= 200)
    begin
        num_errors++;
        final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
endtask
// Stage size, list address and count, then enable
task automatic stage(input logic [31:0] lo, input logic [31:0] cnt);
    apb(1, HBD_SIZE_OFS, 32'h40);
    apb(1, HBD_LIST_LO_OFS, lo);
    apb(1, HBD_LIST_HI_OFS, 32'h2);
    apb(1, HBD_COUNT_OFS, cnt);
    apb(1, HBD_CTRL_OFS, 32'h1);
endtask
// Poll the done flag with a bounded count
task automatic wait_done;
    rd = 0;
    for (int i = 0; i < 50 && rd[HBD_ST_DONE] !== 1'b1; i++)
        apb(0, HBD_STATUS_OFS, 0);
    chk("done", 1, rd[HBD_ST_DONE]);
endtask
////////////////////////////////////////////////////////////////
initial
begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, HBD_CTRL_OFS, 0);
    chk("enable after reset", 0, rd);
    apb(0, HBD_PAGE_SHIFT_OFS, 0);
    chk("page shift", 12, rd);
    // Low list address bits set on purpose; they must be ignored
    stage(32'h1000_0007, 3);
    wait_done();
    chk("segment count", 3, sa.size());
    for (int k = 0; k < 3; k++)
    begin
        chk("seg_addr", (64'h2_1000_0000 + 16 * k) << 12, sa[k]);
        chk("seg_pages", 32'h2100_0001 + k, sp[k]);
    end
    apb(0, HBD_TOTAL_OFS, 0);
    chk("total pages", 32'h6300_0006, rd);
    for (int k = 0; k < 6; k++)
    begin
        apb(1, HBD_ATTR_IDX_OFS, {22'h0, ix[k]});
        apb(0, HBD_ATTR_DATA_OFS, 0);
        chk("attribute", ex[k], rd);
    end
    apb(0, HBD_CTRL_OFS, 0);
    chk("enabled", 1, rd);
    // Enable while enabled is refused, disable twice is harmless
    apb(1, HBD_CTRL_OFS, 1);
    apb(1, HBD_CTRL_OFS, 0);
    apb(1, HBD_CTRL_OFS, 0);
    apb(0, HBD_CTRL_OFS, 0);
    chk("disabled", 0, rd);
    apb(0, HBD_STATUS_OFS, 0);
    chk("status", 32'ha, rd);
    apb(1, HBD_STATUS_OFS, 32'he);
    // Disable during a slow fetch, in wait, at the response and in request
    slow <= 1'b1;
    for (int j = 2; j < 6; j++)
    begin
        stage(32'h3000, 8);
        repeat (j) @(posedge pclk);
        apb(1, HBD_CTRL_OFS, 0);
        n = nreq;
        m = sa.size();
        repeat (40) @(posedge pclk);
        chk("fetches after disable", n, nreq);
        chk("segments after disable", m, sa.size());
    end
    // Larger page: second entry start is no longer page aligned
    apb(1, HBD_STATUS_OFS, 32'he);
    apb(1, HBD_PAGE_SHIFT_OFS, 32'h11);
    stage(32'h4000, 2);
    wait_done();
    apb(0, HBD_STATUS_OFS, 0);
    chk("segment error", 32'hc, rd);
    apb(1, HBD_CTRL_OFS, 0);
    // Empty list: done with no fetch at all
    apb(1, HBD_STATUS_OFS, 32'he);
    n = nreq;
    stage(32'h4000, 0);
    wait_done();
    chk("fetches for empty list", n, nreq);
    apb(0, 12'h100, 0);
    chk("unmapped error", 1, err);
    chk("unmapped data", 0, rd);
    final_report();
end
endmodule
`default_nettype wire
